// ---- src/phy_mgmt_pkg.sv ----
// Constants and types shared by the management register block
package phy_mgmt_pkg;

   // Register addresses on the management bus
   localparam logic [4:0]  REG_STATUS    = 5'h01;
   localparam logic [4:0]  REG_ID_HIGH   = 5'h02;
   localparam logic [4:0]  REG_ID_LOW    = 5'h03;
   localparam logic [4:0]  REG_ADVERTISE = 5'h04;
   localparam logic [4:0]  REG_PARTNER   = 5'h05;

   // Basic status field positions and fixed upper bits 15:6
   localparam int          BIT_AN_DONE   = 5;
   localparam int          BIT_REM_FAULT = 4;
   localparam int          BIT_AN_ABLE   = 3;
   localparam int          BIT_LINK      = 2;
   localparam int          BIT_JABBER    = 1;
   localparam int          BIT_EXT_CAP   = 0;
   localparam logic [9:0]  STATUS_UPPER  = 10'h1E1;

   // Advertisement field positions, write mask and reset value
   localparam int          ADV_NEXT_PAGE = 15;
   localparam int          ADV_REM_FAULT = 13;
   localparam int          ADV_ASYM      = 11;
   localparam int          ADV_PAUSE     = 10;
   localparam int          ADV_T4        = 9;
   localparam int          ADV_ABIL_LSB  = 5;
   localparam logic [15:0] ADV_WRITE_MASK = 16'hADFF;
   localparam logic [15:0] ADV_RESET      = 16'h01E1;

   // Partner ability bits carried: 15, 14, 13, 11, 10
   localparam logic [15:0] PARTNER_MASK   = 16'hEC00;

   // Management frame
   localparam logic [5:0]  PREAMBLE_LEN  = 6'h20;
   localparam logic [1:0]  OP_READ       = 2'h2;
   localparam logic [1:0]  OP_WRITE      = 2'h1;
   localparam logic [5:0]  ADDR_LAST     = 6'h09;
   localparam logic [5:0]  DATA_LAST     = 6'h0F;

   typedef struct packed {
      logic anDone;    // negotiation finished
      logic farFault;  // far-end or partner remote fault
      logic linkUp;    // link valid at 10 or 100
      logic jabber;    // jabber condition
      logic is10m;     // 10 Mb twisted-pair operation
   } phy_status_t;

   typedef enum {HUNT, START, OPCODE, ADDR, TURN, DATA} frame_state_t;

endpackage

// ---- src/phy_mgmt_regs.sv ----
// Management register block: status, identifier, advertisement, partner
`timescale 1ns/1ps
module phy_mgmt_regs import phy_mgmt_pkg::*; #(
   parameter logic [21:0] OUI_CODE  = 22'h0ABCDE, // Arbitrary value
   parameter logic [5:0]  MODEL_NUM = 6'h15,      // Arbitrary value
   parameter logic [3:0]  REVISION  = 4'h3,       // Arbitrary value
   parameter logic [4:0]  PHY_ADDR  = 5'h01       // Station address
) (
   input  wire logic        mclk,         // System clock
   input  wire logic        nrst,         // Async reset, active low
   input  wire logic        mdc,          // Management clock pin
   input  wire logic        mdioIn,       // Management data pin level
   output logic             mdioOut,      // Management data drive value
   output logic             mdioDriveN,   // Low while driving data pin
   input  wire phy_status_t phyStat,      // Live link conditions
   input  wire logic [15:0] partnerWord,  // Received link code word
   input  wire logic [3:0]  abilityStrap, // Ability straps 8:5
   output logic [15:0]      advWord       // Advertised code word
);

   logic [2:0]   mdcSync;
   logic [2:0]   mdioSync;
   logic         mdcLevel;
   logic         mdioLevel;
   logic         next_mdcLevel;
   logic         next_mdioLevel;
   logic         rise;
   logic         fall;
   logic         bitIn;

   frame_state_t state;
   frame_state_t next_state;
   logic [5:0]   cnt;
   logic [5:0]   next_cnt;
   logic         opRead;
   logic         next_opRead;
   logic         phyHit;
   logic         next_phyHit;
   logic [4:0]   regAddr;
   logic [4:0]   next_regAddr;
   logic [15:0]  shiftIn;
   logic [15:0]  next_shiftIn;
   logic [15:0]  shiftOut;
   logic [15:0]  next_shiftOut;
   logic         suppressOk;
   logic         next_suppressOk;
   logic         next_mdioOut;
   logic         next_mdioDriveN;
   logic [1:0]   opCode;
   logic         opValid;
   logic         readTaken;

   logic [15:0]  advertise;
   logic [15:0]  next_advertise;
   logic [15:0]  next_advWord;
   logic         strapDone;
   logic         remLatch;
   logic         next_remLatch;
   logic         linkLatch;
   logic         next_linkLatch;
   logic         jabLatch;
   logic         next_jabLatch;
   logic [15:0]  statusWord;
   logic [15:0]  readData;

   // Pin synchronisers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mdcSync   <= 3'h0;
         mdioSync  <= 3'h7;
         mdcLevel  <= 1'b0;
         mdioLevel <= 1'b1;
      end else begin
         mdcSync   <= {mdcSync[1:0], mdc};
         mdioSync  <= {mdioSync[1:0], mdioIn};
         mdcLevel  <= next_mdcLevel;
         mdioLevel <= next_mdioLevel;
      end
   end

   always_comb begin
      next_mdcLevel  = (mdcSync[2] == mdcSync[1]) ? mdcSync[2] : mdcLevel;
      next_mdioLevel = (mdioSync[2] == mdioSync[1]) ? mdioSync[2]
                                                     : mdioLevel;
      rise  = next_mdcLevel & ~mdcLevel;
      fall  = ~next_mdcLevel & mdcLevel;
      bitIn = next_mdioLevel;
   end

   // Register read mux
   always_comb begin
      statusWord              = {STATUS_UPPER, 6'h00};
      statusWord[BIT_AN_DONE]   = phyStat.anDone;
      statusWord[BIT_REM_FAULT] = remLatch;
      statusWord[BIT_AN_ABLE]   = 1'b1;
      statusWord[BIT_LINK]      = linkLatch;
      statusWord[BIT_JABBER]    = jabLatch;
      statusWord[BIT_EXT_CAP]   = 1'b1;
      unique case (regAddr)
         REG_STATUS:    readData = statusWord;
         REG_ID_HIGH:   readData = OUI_CODE[21:6];
         REG_ID_LOW:    readData = {OUI_CODE[5:0], MODEL_NUM,
                                    REVISION};
         REG_ADVERTISE: readData = advertise;
         REG_PARTNER:   readData = partnerWord
                                   & PARTNER_MASK;
         default:       readData = 16'h0000;
      endcase
   end

   // Frame engine next state
   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_opRead     = opRead;
      next_phyHit     = phyHit;
      next_regAddr    = regAddr;
      next_shiftIn    = shiftIn;
      next_shiftOut   = shiftOut;
      next_suppressOk = suppressOk;
      next_mdioOut    = mdioOut;
      next_mdioDriveN = mdioDriveN;
      next_advertise  = advertise;
      readTaken       = 1'b0;
      opCode          = {shiftIn[0], bitIn};
      opValid         = (opCode == OP_READ) || (opCode == OP_WRITE);
      if (!strapDone) begin
         next_advertise[8:ADV_ABIL_LSB] = abilityStrap;
      end
      if (rise) begin
         next_shiftIn = {shiftIn[14:0], bitIn};
         unique case (state)
            HUNT: begin
               if (bitIn) begin
                  if (cnt != PREAMBLE_LEN) begin
                     next_cnt = cnt + 6'h01;
                  end
               end else begin
                  if (cnt == PREAMBLE_LEN || suppressOk) begin
                     next_state = START;
                  end
                  next_cnt = 6'h00;
               end
            end
            START: begin
               next_state = bitIn ? OPCODE : HUNT;
               next_cnt   = 6'h00;
            end
            OPCODE: begin
               if (cnt == 6'h00) begin
                  next_cnt = 6'h01;
               end else if (opValid) begin
                  next_opRead = (opCode == OP_READ);
                  next_state  = ADDR;
                  next_cnt    = 6'h00;
               end else begin
                  next_suppressOk = 1'b0;
                  next_state      = HUNT;
                  next_cnt        = 6'h00;
               end
            end
            ADDR: begin
               if (cnt == ADDR_LAST) begin
                  next_phyHit  = (shiftIn[8:4] == PHY_ADDR);
                  next_regAddr = {shiftIn[3:0], bitIn};
                  next_state   = TURN;
                  next_cnt     = 6'h00;
               end else begin
                  next_cnt = cnt + 6'h01;
               end
            end
            TURN: begin
               if ((!opRead && (cnt == 6'h00) != bitIn)) begin
                  next_suppressOk = 1'b0;
                  next_state      = HUNT;
                  next_cnt        = 6'h00;
               end else if (cnt == 6'h00) begin
                  next_cnt = 6'h01;
               end else begin
                  next_suppressOk = 1'b1;
                  next_state      = DATA;
                  next_cnt        = 6'h00;
               end
            end
            DATA: begin
               if (cnt == DATA_LAST) begin
                  next_state = HUNT;
                  next_cnt   = 6'h00;
                  if (!opRead && phyHit && regAddr == REG_ADVERTISE) begin
                     next_advertise = (advertise & ~ADV_WRITE_MASK)
                        | ({shiftIn[14:0], bitIn}
                           & ADV_WRITE_MASK);
                  end
               end else begin
                  next_cnt = cnt + 6'h01;
               end
            end
         endcase
      end
      if (fall) begin
         if (state == TURN && opRead && phyHit && cnt == 6'h01) begin
            next_mdioDriveN = 1'b0;
            next_mdioOut    = 1'b0;
            next_shiftOut   = readData;
            readTaken       = (regAddr == REG_STATUS);
         end else if (state == DATA && opRead && phyHit) begin
            next_mdioOut  = shiftOut[15];
            next_shiftOut = {shiftOut[14:0], 1'b0};
         end else begin
            next_mdioDriveN = 1'b1;
            next_mdioOut    = 1'b0;
         end
      end
   end

   // Latched status bits, set wins over read clear
   always_comb begin
      next_remLatch  = (remLatch & ~readTaken) | phyStat.farFault;
      next_linkLatch = readTaken ? phyStat.linkUp
                                 : (linkLatch & phyStat.linkUp);
      next_jabLatch  = (jabLatch & ~readTaken)
                       | (phyStat.jabber & phyStat.is10m);
      next_advWord   = advertise;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state      <= HUNT;
         cnt        <= 6'h00;
         opRead     <= 1'b0;
         phyHit     <= 1'b0;
         regAddr    <= 5'h00;
         shiftIn    <= 16'h0000;
         shiftOut   <= 16'h0000;
         suppressOk <= 1'b0;
         mdioOut    <= 1'b0;
         mdioDriveN <= 1'b1;
         advertise  <= ADV_RESET;
         advWord    <= ADV_RESET;
         strapDone  <= 1'b0;
         remLatch   <= 1'b0;
         linkLatch  <= 1'b0;
         jabLatch   <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         opRead     <= next_opRead;
         phyHit     <= next_phyHit;
         regAddr    <= next_regAddr;
         shiftIn    <= next_shiftIn;
         shiftOut   <= next_shiftOut;
         suppressOk <= next_suppressOk;
         mdioOut    <= next_mdioOut;
         mdioDriveN <= next_mdioDriveN;
         advertise  <= next_advertise;
         advWord    <= next_advWord;
         strapDone  <= 1'b1;
         remLatch   <= next_remLatch;
         linkLatch  <= next_linkLatch;
         jabLatch   <= next_jabLatch;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_bad_opcode;
      rise && state == OPCODE && cnt == 6'h01 && !opValid;
   endsequence

   sequence s_turn_read;
      fall && state == TURN && opRead && phyHit && cnt == 6'h01;
   endsequence

   a_status_fixed: assert property (regAddr == REG_STATUS |->
      readData[BIT_AN_ABLE] && readData[BIT_EXT_CAP]
      && readData[BIT_AN_DONE] == phyStat.anDone)
      else $error("status fixed or completion bit wrong");
   a_fault_latch: assert property (phyStat.farFault |=> remLatch)
      else $error("remote fault not latched");
   a_fault_clear: assert property (
      readTaken && !phyStat.farFault |=> !remLatch)
      else $error("remote fault not reloaded on read");
   // Only a status read in the middle cycle may lift the latch
   a_link_low: assert property (
      !phyStat.linkUp |=> !linkLatch ##1 (!linkLatch || $past(readTaken)))
      else $error("link bit not latched low");
   a_link_reload: assert property (
      readTaken && phyStat.linkUp |=> linkLatch)
      else $error("link bit not reloaded when up");
   a_jabber_latch: assert property (
      phyStat.jabber && phyStat.is10m |=> jabLatch)
      else $error("jabber not latched");
   a_id_high: assert property (regAddr == REG_ID_HIGH |->
      readData == OUI_CODE[21:6])
      else $error("first identifier wrong");
   a_id_low: assert property (regAddr == REG_ID_LOW |->
      readData == {OUI_CODE[5:0], MODEL_NUM, REVISION})
      else $error("second identifier wrong");
   a_adv_fixed: assert property (
      !advertise[ADV_T4] && (advertise & ~ADV_WRITE_MASK) == 16'h0000)
      else $error("advertisement fixed bits not zero");

   a_adv_out: assert property (##1 advWord == $past(advertise))
      else $error("advertised word does not follow register");

   a_suppress_clear: assert property (s_bad_opcode |=> !suppressOk)
      else $error("bad opcode kept preamble suppression");

   a_turn_drive: assert property (
      s_turn_read |=> !mdioDriveN && !mdioOut)
      else $error("read turnaround not driven low");

endmodule // phy_mgmt_regs

// ---- testbench/mgmt_master.sv ----
// Station management master model for the serial management pins
`timescale 1ns/1ps
module mgmt_master (
   input  wire logic mclk,     // System clock
   input  wire logic mdioLine, // Resolved data line
   output logic      mdc,      // Management clock
   output logic      mBit,     // Data value driven
   output logic      mDrive    // High while driving
);
   int half = 6;

   initial begin
      mdc = 1'b0;
      mBit = 1'b1;
      mDrive = 1'b0;
   end

   // One mdc period; data changes only while mdc is low
   task automatic cycle(input logic b, input logic drv, output logic s);
      mDrive = drv;
      mBit = b;
      repeat (half) @(posedge mclk);
      #1 mdc = 1'b1;
      repeat (half) @(posedge mclk);
      s = mdioLine;
      #1 mdc = 1'b0;
   endtask

   task automatic frame(input logic pre, input logic [1:0] op,
         input logic [4:0] pa, input logic [4:0] ra,
         input logic [1:0] ta, input logic [15:0] wd,
         output logic [15:0] rd);
      logic        s;
      logic        rdOp;
      logic [13:0] head;
      head = {2'b01, op, pa, ra};
      rdOp = (op == 2'b10);
      if (pre)
         repeat (32) cycle(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--)
         cycle(head[i], 1'b1, s);
      for (int i = 1; i >= 0; i--)
         cycle(ta[i], !rdOp, s);
      for (int i = 15; i >= 0; i--) begin
         cycle(wd[i], !rdOp, s);
         rd[i] = s;
      end
      // Idle bit lets the device release before the next frame
      cycle(1'b1, 1'b0, s);
   endtask
endmodule // mgmt_master

// ---- testbench/tb.sv ----
// Self-checking bench for the management register block
`timescale 1ns/1ps
module tb;
   import phy_mgmt_pkg::*;
   localparam logic [21:0] OUI   = 22'h2A5C3; // Arbitrary value
   localparam logic [5:0]  MODEL = 6'h2B;     // Arbitrary value
   localparam logic [3:0]  REV   = 4'h9;      // Arbitrary value
   localparam logic [4:0]  ADDR  = 5'h07;

   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        mdc, mBit, mDrive, mdioOut, mdioDriveN, mdioWire;
   phy_status_t phyStat = '0;
   logic [15:0] partnerWord = 16'h0000;
   logic [3:0]  abilityStrap;
   logic [15:0] advWord, rd, adv, wd;
   logic [9:0]  pair;
   logic        fltL = 1'b0;
   logic        lnkL = 1'b0;
   logic        jabL = 1'b0;
   int          errors = 0;
   int          n_checks = 0;
   int          seed = 33;
   logic [9:0]  cornerTab [8] = '{10'h084, 10'h084, 10'h004, 10'h084,
                                  10'h040, 10'h060, 10'h100, 10'h210};
   logic [1:0]  badOp [3] = '{2'b01, 2'b00, 2'b11};

   always #2 mclk = ~mclk;

   // Pull-up holds the line high when nobody drives
   assign mdioWire = !mdioDriveN ? mdioOut : (mDrive ? mBit : 1'b1);

   mgmt_master mgr (.mclk(mclk), .mdioLine(mdioWire), .mdc(mdc),
                    .mBit(mBit), .mDrive(mDrive));

   phy_mgmt_regs #(.OUI_CODE(OUI), .MODEL_NUM(MODEL), .REVISION(REV),
                   .PHY_ADDR(ADDR)) dut_u (
      .mclk(mclk), .nrst(nrst), .mdc(mdc), .mdioIn(mdioWire),
      .mdioOut(mdioOut), .mdioDriveN(mdioDriveN), .phyStat(phyStat),
      .partnerWord(partnerWord), .abilityStrap(abilityStrap),
      .advWord(advWord));

   task automatic check(input string name, input logic [15:0] seen,
         input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
      mgr.frame(1'b0, OP_READ, ADDR, ra, 2'b10, 16'h0000, d);
   endtask

   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] unused;
      mgr.frame(1'b0, OP_WRITE, ADDR, ra, 2'b10, d, unused);
   endtask

   // Apply live conditions and track the latched view
   task automatic set_stat(input phy_status_t s);
      phyStat = s;
      fltL |= s.farFault;
      jabL |= s.jabber & s.is10m;
      lnkL &= s.linkUp;
      repeat (10) @(posedge mclk);
      #1;
   endtask

   function automatic logic [15:0] exp_status();
      return {10'h1E1, phyStat.anDone, fltL, 1'b1, lnkL, jabL, 1'b1};
   endfunction

   initial begin
      repeat (100000) @(posedge mclk);
      errors++;
      close_out();
   end

   initial begin
      abilityStrap = 4'($random(seed));
      repeat (8) @(posedge mclk);
      check("adv in reset", advWord, 16'h01E1);
      check("release in reset", {15'h0000, mdioDriveN}, 16'h0001);
      #1 nrst = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      adv = {7'h00, abilityStrap, 5'h01};
      check("adv strap", advWord, adv);
      mgr.frame(1'b1, OP_READ, ADDR, REG_ID_HIGH, 2'b10, 16'h0000, rd);
      check("id high", rd, OUI[21:6]);
      rd_reg(REG_ID_LOW, rd);
      check("id low", rd, {OUI[5:0], MODEL, REV});
      for (int i = 0; i < 24; i++) begin
         pair = (i < 8) ? cornerTab[i] : 10'($random(seed));
         mgr.half = (i % 5 == 4) ? 12 : 4;
         set_stat(pair[9:5]);
         set_stat(pair[4:0]);
         rd_reg(REG_STATUS, rd);
         check("status", rd, exp_status());
         fltL = phyStat.farFault;
         jabL = phyStat.jabber & phyStat.is10m;
         lnkL = phyStat.linkUp;
      end
      for (int i = 0; i < 10; i++) begin
         wd = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
         wr_reg(REG_ADVERTISE, wd);
         // Writable: 15, 13, 11, 10, 8:0
         adv = wd & 16'hADFF;
         check("adv word", advWord, adv);
         rd_reg(REG_ADVERTISE, rd);
         check("adv read", rd, adv);
      end
      for (int i = 0; i < 6; i++) begin
         partnerWord = (i == 0) ? 16'hFFFF : 16'($random(seed));
         wr_reg(REG_PARTNER, ~partnerWord);
         rd_reg(REG_PARTNER, rd);
         check("partner", rd, partnerWord & 16'hEC00);
      end
      wr_reg(REG_ID_HIGH, 16'h0000);
      rd_reg(REG_ID_HIGH, rd);
      check("id high kept", rd, OUI[21:6]);
      rd_reg(5'h06, rd);
      check("unmapped", rd, 16'h0000);
      foreach (badOp[k]) begin
         mgr.frame(1'b0, badOp[k], ADDR, REG_ADVERTISE, 2'b11, 16'h0000, rd);
         rd_reg(REG_ID_HIGH, rd);
         check("no preamble after abort", rd, 16'hFFFF);
         mgr.frame(1'b1, OP_READ, ADDR, REG_ADVERTISE, 2'b10, 16'h0000, rd);
         check("adv after abort", rd, adv);
      end
      close_out();
   end
endmodule // tb
